// [design/dbs_pkg.sv]
package dbs_pkg;
    localparam int PERMIT_BIT = 7;
    localparam int HALTED_BIT = 6;
    localparam int BKEN_BIT   = 5;
    localparam int FORCE_BIT  = 4;
    localparam int CLKSEL_BIT = 3;
    localparam int LPSTAT_BIT = 2;
    localparam int LPFAIL_BIT = 1;
    localparam int SLOWF_BIT  = 0;

    localparam logic        CTRL_BIT_RESET = 1'b0;
    localparam logic [15:0] BKPT_RESET     = 16'h0000;

    typedef enum logic [2:0] {
        DBS_CMD_RD_STAT = 3'h0,
        DBS_CMD_WR_CTRL = 3'h1,
        DBS_CMD_RD_BKPT = 3'h2,
        DBS_CMD_WR_BKPT = 3'h3,
        DBS_CMD_HALT    = 3'h4,
        DBS_CMD_MEM     = 3'h5
    } dbs_cmd_t;

    typedef enum logic {
        DBS_BK_IDLE = 1'b0,
        DBS_BK_PEND = 1'b1
    } dbs_bk_t;
endpackage : dbs_pkg

// [design/dbs_bkpt_if.sv]
`timescale 1ns/1ps
interface dbs_bkpt_if;
    logic        en;
    logic        force_sel;
    logic [15:0] bkpt;
    logic [15:0] addr;
    logic        addr_valid;
    logic        fetch;
    logic        boundary;
    logic        tag_exec;
    logic        tag;
    logic        brk;

    modport ctl (output en, force_sel, bkpt, addr, addr_valid, fetch, boundary, tag_exec, input tag, brk);
    modport mat (input en, force_sel, bkpt, addr, addr_valid, fetch, boundary, tag_exec, output tag, brk);
endinterface : dbs_bkpt_if

// [design/dbs_bkpt.sv]
`timescale 1ns/1ps
module dbs_bkpt
    import dbs_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    dbs_bkpt_if.mat    bp
);
    dbs_bk_t st_q;
    dbs_bk_t st_d;
    logic    brk_q;
    logic    brk_d;
    logic    match;

    // a disabled breakpoint ignores the force choice and the address register
    assign match  = bp.en && bp.addr_valid && (bp.addr == bp.bkpt);
    assign bp.tag = match && !bp.force_sel && bp.fetch;
    assign bp.brk = brk_q;

    always_comb begin
        st_d  = st_q;
        brk_d = 1'b0;
        case (st_q)
            DBS_BK_IDLE: begin
                if (match && bp.force_sel) begin
                    st_d = DBS_BK_PEND;
                end
            end
            DBS_BK_PEND: begin
                if (!bp.en) begin
                    st_d = DBS_BK_IDLE;
                end else if (bp.boundary) begin
                    st_d  = DBS_BK_IDLE;
                    brk_d = 1'b1;
                end
            end
            default: st_d = DBS_BK_IDLE;
        endcase
        // besides a force boundary in DBS_BK_PEND, only a tagged opcode that actually executes breaks
        if (bp.en && !bp.force_sel && bp.tag_exec) begin
            brk_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q  <= DBS_BK_IDLE;
            brk_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            brk_q <= brk_d;
        end
    end

    bkpt_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bp.en |-> !bp.tag ##1 !bp.brk)
        else $error("breakpoint active while disabled");
    force_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == DBS_BK_PEND) && bp.en && bp.boundary |=> bp.brk)
        else $error("force breakpoint missed boundary");
    tag_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
        bp.en && !bp.force_sel && bp.tag_exec |=> bp.brk)
        else $error("tagged opcode did not break");
    tag_mark_a: assert property (@(posedge clk) disable iff (!rst_n)
        bp.tag |-> bp.fetch && !bp.force_sel && bp.addr == bp.bkpt)
        else $error("tag without matching fetch");
endmodule : dbs_bkpt

// [design/dbs_top.sv]
`timescale 1ns/1ps
module dbs_top
    import dbs_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        CMD_VALID,
    input  wire logic [2:0]  CMD_CODE,
    input  wire logic [15:0] CMD_WDATA,
    output logic             CMD_DONE,
    output logic             CMD_OK,
    output logic [15:0]      CMD_RDATA,
    input  wire logic [15:0] CPU_ADDR,
    input  wire logic        CPU_ADDR_VALID,
    input  wire logic        CPU_FETCH,
    input  wire logic        CPU_BOUNDARY,
    input  wire logic        CPU_TAG_EXEC,
    input  wire logic        CPU_HALTED,
    input  wire logic        CPU_LOWPOWER,
    input  wire logic        CPU_LP_ENTER,
    output logic             CPU_TAG,
    output logic             HALT_REQ,
    output logic             SWI_REQ,
    output logic             LINK_CLK_SEL
);
    logic        permit_q,  permit_d;
    logic        bken_q,    bken_d;
    logic        force_q,   force_d;
    logic        clksel_q,  clksel_d;
    logic        lpfail_q,  lpfail_d;
    logic        woke_q,    woke_d;
    logic [15:0] bkpt_q,    bkpt_d;
    logic        halt_q,    halt_d;
    logic        swi_q,     swi_d;
    logic        done_q,    done_d;
    logic        ok_q,      ok_d;
    logic [15:0] rdata_q,   rdata_d;
    logic        lp_status;
    logic        mem_conflict;
    logic [7:0]  status;
    dbs_cmd_t    cmd;

    dbs_bkpt_if bp ();

    assign bp.en         = bken_q;
    assign bp.force_sel  = force_q;
    assign bp.bkpt       = bkpt_q;
    assign bp.addr       = CPU_ADDR;
    assign bp.addr_valid = CPU_ADDR_VALID;
    assign bp.fetch      = CPU_FETCH;
    assign bp.boundary   = CPU_BOUNDARY;
    assign bp.tag_exec   = CPU_TAG_EXEC;

    dbs_bkpt u_bkpt (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .bp    (bp)
    );

    assign cmd          = dbs_cmd_t'(CMD_CODE);
    assign lp_status    = CPU_LOWPOWER || (woke_q && CPU_HALTED);
    assign mem_conflict = CPU_LOWPOWER || CPU_LP_ENTER;

    // status mixes hardware flags with the permit, bken, force and clksel control bits, so a control write changes those, permit only while not halted
    always_comb begin
        status             = 8'h00;
        status[PERMIT_BIT] = permit_q;
        status[HALTED_BIT] = CPU_HALTED;
        status[BKEN_BIT]   = bken_q;
        status[FORCE_BIT]  = force_q;
        status[CLKSEL_BIT] = clksel_q;
        status[LPSTAT_BIT] = lp_status;
        status[LPFAIL_BIT] = lpfail_q;
        status[SLOWF_BIT]  = 1'b0;
    end

    always_comb begin
        permit_d = permit_q;
        bken_d   = bken_q;
        force_d  = force_q;
        clksel_d = clksel_q;
        lpfail_d = lpfail_q;
        // kept while the halt request still waits for the cpu to stop and while the cpu stays halted
        woke_d   = woke_q && (CPU_HALTED || halt_q);
        bkpt_d   = bkpt_q;
        halt_d   = halt_q && !CPU_HALTED;
        swi_d    = 1'b0;
        done_d   = CMD_VALID;
        ok_d     = 1'b0;
        rdata_d  = rdata_q;
        if (CMD_VALID) begin
            ok_d = 1'b1;
            case (cmd)
                DBS_CMD_RD_STAT: rdata_d = {8'h00, status};
                DBS_CMD_WR_CTRL: begin
                    // changing the permit while halted would be ambiguous
                    if (!CPU_HALTED) begin
                        permit_d = CMD_WDATA[PERMIT_BIT];
                    end
                    bken_d   = CMD_WDATA[BKEN_BIT];
                    force_d  = CMD_WDATA[FORCE_BIT];
                    clksel_d = CMD_WDATA[CLKSEL_BIT];
                end
                DBS_CMD_RD_BKPT: rdata_d = bkpt_q;
                DBS_CMD_WR_BKPT: bkpt_d  = CMD_WDATA;
                DBS_CMD_HALT: begin
                    if (!permit_q) begin
                        ok_d = 1'b0;
                    end else if (!CPU_HALTED) begin
                        halt_d = 1'b1;
                        woke_d = CPU_LOWPOWER;
                    end
                end
                DBS_CMD_MEM: begin
                    if (mem_conflict) begin
                        ok_d     = 1'b0;
                    end else begin
                        lpfail_d = 1'b0;
                    end
                end
                default: ok_d = 1'b0;
            endcase
        end
        // set wins over the clear by a clean access
        if (CMD_VALID && cmd == DBS_CMD_MEM && mem_conflict) begin
            lpfail_d = 1'b1;
        end
        if (bp.brk && !CPU_HALTED) begin
            if (permit_q) begin
                halt_d = 1'b1;
            end else begin
                swi_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            permit_q <= CTRL_BIT_RESET;
            bken_q   <= CTRL_BIT_RESET;
            force_q  <= CTRL_BIT_RESET;
            clksel_q <= CTRL_BIT_RESET;
            lpfail_q <= CTRL_BIT_RESET;
            woke_q   <= 1'b0;
            bkpt_q   <= BKPT_RESET;
            halt_q   <= 1'b0;
            swi_q    <= 1'b0;
            done_q   <= 1'b0;
            ok_q     <= 1'b0;
            rdata_q  <= 16'h0000;
        end else begin
            permit_q <= permit_d;
            bken_q   <= bken_d;
            force_q  <= force_d;
            clksel_q <= clksel_d;
            lpfail_q <= lpfail_d;
            woke_q   <= woke_d;
            bkpt_q   <= bkpt_d;
            halt_q   <= halt_d;
            swi_q    <= swi_d;
            done_q   <= done_d;
            ok_q     <= ok_d;
            rdata_q  <= rdata_d;
        end
    end

    assign CMD_DONE     = done_q;
    assign CMD_OK       = ok_q;
    assign CMD_RDATA    = rdata_q;
    assign CPU_TAG      = bp.tag;
    assign HALT_REQ     = halt_q;
    assign SWI_REQ      = swi_q;
    assign LINK_CLK_SEL = clksel_q;

    halt_refuse_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CMD_VALID && cmd == DBS_CMD_HALT && !permit_q |=> CMD_DONE && !CMD_OK)
        else $error("halt accepted without permit");
    permit_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CMD_VALID && cmd == DBS_CMD_WR_CTRL && CPU_HALTED |=> permit_q == $past(permit_q))
        else $error("permit changed while halted");
    status_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CMD_VALID && cmd == DBS_CMD_RD_STAT |=>
            CMD_RDATA[HALTED_BIT] == $past(CPU_HALTED) && !CMD_RDATA[SLOWF_BIT])
        else $error("status read wrong");
    lp_fail_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CMD_VALID && cmd == DBS_CMD_MEM && CPU_LOWPOWER |=> lpfail_q && !CMD_OK)
        else $error("memory conflict not flagged");
    lp_status_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CMD_VALID && cmd == DBS_CMD_RD_STAT && CPU_LOWPOWER |=> CMD_RDATA[LPSTAT_BIT])
        else $error("lowpower status missing");
    clk_select_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CMD_VALID && cmd == DBS_CMD_WR_CTRL |=> LINK_CLK_SEL == $past(CMD_WDATA[CLKSEL_BIT]))
        else $error("clock select not written");
    swi_break_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        bp.brk && !permit_q && !CPU_HALTED |=> SWI_REQ)
        else $error("software interrupt missing");
    lp_wake_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CMD_VALID && cmd == DBS_CMD_HALT && permit_q && CPU_LOWPOWER && !CPU_HALTED
            |=> HALT_REQ && CMD_OK)
        else $error("halt from lowpower refused");
endmodule : dbs_top

// [tb/dbs_host.sv]
`timescale 1ns/1ps
module dbs_host
    import dbs_pkg::*;
(
    input  wire logic        clk,
    output logic             cmd_valid,
    output logic [2:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 3'h0;
        cmd_wdata = 16'h0000;
    end

    // valid is left high so that two calls in a row give back-to-back commands
    task automatic send(input logic [2:0] code, input logic [15:0] data);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_wdata <= data;
    endtask : send

    // a released data bus flips every cycle so a stale word can never look valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            cmd_valid <= 1'b0;
            cmd_wdata <= ~cmd_wdata;
        end
    endtask : idle
endmodule : dbs_host

// [tb/dbs_top_tb.sv]
`timescale 1ns/1ps
module dbs_top_tb;
    import dbs_pkg::*;
    logic        clock, rst_n, cmd_valid, cmd_done, cmd_ok, cpu_addr_valid, cpu_fetch, cpu_boundary;
    logic        cpu_tag_exec, cpu_halted, cpu_lowpower, cpu_lp_enter, cpu_tag, halt_req, swi_req, link_clk_sel;
    logic [2:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, cpu_addr, bk;
    logic [17:0] exp_q[$];
    int          fails = 0;
    int          tests_run = 0;
    int          seed = 32'hd673c6d1;

    dbs_host i_dbs_host (.clk(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    dbs_top i_dbs_top (.CLOCK(clock), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
        .CMD_WDATA(cmd_wdata), .CMD_DONE(cmd_done), .CMD_OK(cmd_ok), .CMD_RDATA(cmd_rdata),
        .CPU_ADDR(cpu_addr), .CPU_ADDR_VALID(cpu_addr_valid), .CPU_FETCH(cpu_fetch),
        .CPU_BOUNDARY(cpu_boundary), .CPU_TAG_EXEC(cpu_tag_exec), .CPU_HALTED(cpu_halted),
        .CPU_LOWPOWER(cpu_lowpower), .CPU_LP_ENTER(cpu_lp_enter), .CPU_TAG(cpu_tag),
        .HALT_REQ(halt_req), .SWI_REQ(swi_req), .LINK_CLK_SEL(link_clk_sel));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : chk

    task automatic tally_and_finish;
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // the note is queued first; the watcher below compares it when the answer shows
    task automatic cmd(input logic [2:0] code, input logic [15:0] data, input logic ok, input logic rd,
                       input logic [15:0] val);
        exp_q.push_back({rd, ok, val});
        i_dbs_host.send(code, data);
    endtask : cmd

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
    endtask : do_reset

    // drives one cpu pulse and looks at a request one and two cycles later
    task automatic pulse_then(input int which, input logic halt_want, input logic swi_want);
        @(posedge clock);
        if (which == 0) cpu_boundary <= 1'b1; else cpu_tag_exec <= 1'b1;
        @(posedge clock);
        cpu_boundary <= 1'b0;
        cpu_tag_exec <= 1'b0;
        #1 chk(halt_req | swi_req, 0, "request too early");
        @(posedge clock);
        #1 chk({swi_req, halt_req}, {swi_want, halt_want}, "break request");
    endtask : pulse_then

    always @(negedge clock) begin : watch_results
        logic [17:0] e;
        if (rst_n === 1'b1 && cmd_done !== 1'b0) begin
            if (exp_q.size() == 0) begin
                chk(cmd_done, 0, "unexpected done");
            end else begin
                e = exp_q.pop_front();
                chk(cmd_ok, e[16], "command ok");
                if (e[17]) chk(cmd_rdata, e[15:0], "read data");
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        tally_and_finish();
    end

    initial begin
        {rst_n, cpu_addr_valid, cpu_fetch, cpu_boundary, cpu_tag_exec} = 5'h00;
        {cpu_halted, cpu_lowpower, cpu_lp_enter} = 3'h0;
        cpu_addr = 16'h0000;
        bk = 16'($random(seed));
        do_reset();
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h0000);
        cmd(3'h2, 16'h0000, 1'b1, 1'b1, 16'h0000);
        cmd(3'h4, 16'h0000, 1'b0, 1'b0, 16'h0000);
        cmd(3'h6, 16'h0000, 1'b0, 1'b0, 16'h0000);
        cmd(3'h7, 16'h0000, 1'b0, 1'b0, 16'h0000);
        i_dbs_host.idle(2);
        #1 chk({halt_req, link_clk_sel}, 0, "idle after reset");
        cmd(3'h1, 16'h00FF, 1'b1, 1'b0, 16'h0000);
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h00B8);
        cmd(3'h3, bk, 1'b1, 1'b0, 16'h0000);
        cmd(3'h2, 16'h0000, 1'b1, 1'b1, bk);
        i_dbs_host.idle(1);
        #1 chk(link_clk_sel, 1, "bus clock chosen");
        // force choice: the match arms, only a later boundary fires
        @(posedge clock);
        cpu_addr <= bk;
        cpu_addr_valid <= 1'b1;
        @(posedge clock);
        cpu_addr <= ~bk;
        cpu_addr_valid <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk(halt_req, 0, "armed without boundary");
        pulse_then(0, 1'b1, 1'b0);
        repeat (5) @(posedge clock);
        #1 chk(halt_req, 1, "halt request held");
        @(posedge clock);
        cpu_halted <= 1'b1;
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h00F8);
        cmd(3'h1, 16'h0000, 1'b1, 1'b0, 16'h0000);
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h00C0);
        cmd(3'h4, 16'h0000, 1'b1, 1'b0, 16'h0000);
        cmd(3'h1, 16'h00A0, 1'b1, 1'b0, 16'h0000);
        i_dbs_host.idle(2);
        #1 chk(halt_req, 0, "no request while halted");
        cpu_halted <= 1'b0;
        // tag choice: fetch is marked, halt only once the opcode executes
        @(posedge clock);
        {cpu_addr_valid, cpu_fetch} <= 2'h3;
        cpu_addr <= bk;
        #1 chk(cpu_tag, 1, "fetch tagged");
        @(posedge clock);
        {cpu_addr_valid, cpu_fetch} <= 2'h0;
        #1 chk({cpu_tag, halt_req}, 0, "tag without halt");
        pulse_then(1, 1'b1, 1'b0);
        @(posedge clock);
        cpu_halted <= 1'b1;
        cmd(3'h1, 16'h0010, 1'b1, 1'b0, 16'h0000);
        i_dbs_host.idle(2);
        cpu_halted <= 1'b0;
        @(posedge clock);
        {cpu_addr_valid, cpu_fetch} <= 2'h3;
        #1 chk(cpu_tag, 0, "disabled breakpoint");
        pulse_then(0, 1'b0, 1'b0);
        {cpu_addr_valid, cpu_fetch} <= 2'h0;
        pulse_then(1, 1'b0, 1'b0);
        // random cpu activity on the match address must never reach a break while disabled
        repeat (32) begin
            @(posedge clock);
            {cpu_addr_valid, cpu_fetch, cpu_boundary, cpu_tag_exec,
             cpu_halted, cpu_lowpower, cpu_lp_enter} <= 7'($random(seed));
            #1 chk({cpu_tag, halt_req, swi_req}, 0, "disabled breakpoint noise");
        end
        {cpu_addr_valid, cpu_fetch, cpu_boundary, cpu_tag_exec,
         cpu_halted, cpu_lowpower, cpu_lp_enter} <= 7'h00;
        do_reset();
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h0000);
        cmd(3'h1, 16'h0020, 1'b1, 1'b0, 16'h0000);
        i_dbs_host.idle(1);
        pulse_then(1, 1'b0, 1'b1);
        #25 chk(swi_req, 0, "one cycle pulse");
        cmd(3'h1, 16'h0080, 1'b1, 1'b0, 16'h0000);
        i_dbs_host.idle(1);
        cpu_lowpower <= 1'b1;
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h0084);
        cmd(3'h5, 16'h0000, 1'b0, 1'b0, 16'h0000);
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h0086);
        cmd(3'h4, 16'h0000, 1'b1, 1'b0, 16'h0000);
        i_dbs_host.idle(1);
        #1 chk(halt_req, 1, "halt from low power");
        cpu_lowpower <= 1'b0;
        i_dbs_host.idle(1);
        cpu_halted <= 1'b1;
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h00C6);
        cmd(3'h5, 16'h0000, 1'b1, 1'b0, 16'h0000);
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h00C4);
        i_dbs_host.idle(1);
        cpu_halted <= 1'b0;
        cmd(3'h5, 16'h0000, 1'b0, 1'b0, 16'h0000);
        cpu_lp_enter <= 1'b1;
        i_dbs_host.idle(1);
        cpu_lp_enter <= 1'b0;
        cmd(3'h0, 16'h0000, 1'b1, 1'b1, 16'h0082);
        i_dbs_host.idle(3);
        chk(16'(exp_q.size()), 0, "answers missing");
        tally_and_finish();
    end
endmodule : dbs_top_tb
